// >>> shared/dcc_pkg.sv
// constants and types for the dispatch and completion control block
package dcc_pkg;
    localparam int CQ_DEPTH = 6;
    localparam int INT_RENAME = 6;
    localparam int FLT_RENAME = 6;
    localparam int MAX_INFLIGHT = 12;
    localparam int MAX_UPD = 2;
    localparam int IQ_VIS = 6;
    localparam logic [3:0] SYNC_CYCLES = 4'h3;
    localparam logic [3:0] SRU_CR_CYCLES = 4'h1;
    localparam logic [3:0] SRU_SEG_CYCLES = 4'h2;
    localparam logic [5:0] OPC_CR_LOGIC = 6'h13;
    localparam logic [9:0] XOP_SEG_IND = 10'h0f2;
    localparam logic [9:0] XOP_SEG_DIR = 10'h0d2;
    localparam logic [5:0] OPC_EXT31 = 6'h1f;
    // execution unit numbers
    localparam logic [2:0] EU_NONE = 3'h0;
    localparam logic [2:0] EU_INT = 3'h1;
    localparam logic [2:0] EU_FLT = 3'h2;
    localparam logic [2:0] EU_LSU = 3'h3;
    localparam logic [2:0] EU_SRU = 3'h4;
    localparam logic [2:0] EU_BR = 3'h5;
    localparam int EU_CNT = 6;
    typedef enum logic [1:0] {
        DCC_SER_NONE,
        DCC_SER_EXEC,
        DCC_SER_COMPL,
        DCC_SER_REFETCH
    } dcc_ser_type;
    typedef enum {
        DCC_SRU_IDLE,
        DCC_SRU_BUSY,
        DCC_SRU_SYNC_DRAIN,
        DCC_SRU_SYNC_BCAST
    } dcc_sru_type;
endpackage

// >>> design/dcc_rename_pool.sv
// free-entry counter for one rename register pool
`timescale 1ns/100ps
module dcc_rename_pool (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // allocation and release counts
    input wire logic [2:0] alloc_cnt,
    input wire logic [2:0] release_cnt,
    // state
    output logic [2:0] free_ff
);
    logic [3:0] nxt_free;

    // pool starts full
    always_comb begin
        nxt_free = 4'(free_ff) + 4'(release_cnt) - 4'(alloc_cnt);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            free_ff <= 3'h6;
        end else begin
            free_ff <= nxt_free[2:0];
        end
    end

    a_pool_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
        free_ff <= 3'h6) else $error("rename pool overflow");
endmodule

// >>> design/dcc_branch_res.sv
// branch resolution resource check and folding decision
`timescale 1ns/100ps
module dcc_branch_res (
    // branch at the branch unit
    input wire logic br_valid,
    input wire logic br_to_link,
    input wire logic br_to_count,
    input wire logic br_and_link,
    input wire logic br_on_cond_bits,
    input wire logic br_updates_ctr,
    input wire logic br_taken,
    // register availability
    input wire logic link_avail,
    input wire logic count_avail,
    input wire logic shadow_link_avail,
    input wire logic unresolved_pred,
    // decisions
    output logic br_stall,
    output logic br_fold,
    output logic br_fall
);
    // stall until needed register is free or the predicted branch resolves
    always_comb begin
        br_stall = br_valid && ((br_to_link && !link_avail) // RULE12
            || (br_to_count && !count_avail)
            || (br_and_link && !shadow_link_avail)
            || (br_on_cond_bits && unresolved_pred)); // RULE13
    end

    // fold or fall through
    always_comb begin
        br_fold = br_valid && !br_stall && !br_updates_ctr && !br_and_link && br_taken; // RULE14
        br_fall = br_valid && !br_stall && !br_updates_ctr && !br_and_link && !br_taken; // RULE14
    end
endmodule

// >>> design/dcc_core_ctrl.sv
// dual-slot dispatch and in-order dual completion control
// Operation
// RULE1: first slot needs unit, renames, queue entry, no serializer running
// RULE2: second slot dispatches only alongside unserialized first, with resources left; code holds it back only for completion or refetch serialization
// RULE3: completion queue holds at most six instructions
// RULE4: six integer renames; without one the instruction waits undispatched
// RULE5: load with update takes two integer renames
// RULE6: six float renames bound float destinations in flight
// RULE7: oldest slot retires when finished, not speculative, no exception
// RULE8: next slot retires only with oldest and under same conditions
// RULE9: next slot retires only integer or load instructions
// RULE10: per cycle at most two condition, integer and float updates
// RULE11: at most twelve instructions between oldest completion and queue end
// RULE12: branch stalls until link, count or shadow link is available
// RULE13: condition-bit branch waits behind unresolved predicted branch
// RULE14: branches not updating count or link fold when taken, else fall through
// RULE15: synchronize takes three cycles, else waits stores and broadcast
// RULE16: tlb synchronize finishes at dispatch, retires on external sync input
// RULE17: condition logical ops run one cycle in system unit, serialized
// RULE18: segment register moves run two cycles in system unit, serialized
// RULE19: software spaces condition setters from branches, beyond ten no gain
// RULE20: retire in order, two at most, freeing renames and entries
`timescale 1ns/100ps
module dcc_core_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // dispatch slots
    input wire logic [1:0] iq_valid,
    input wire logic [1:0][2:0] iq_unit,
    input wire logic [1:0][5:0] iq_opcode,
    input wire logic [1:0][9:0] iq_xop,
    input wire logic [1:0] iq_int_dst,
    input wire logic [1:0] iq_load_update,
    input wire logic [1:0] iq_flt_dst,
    input wire logic [1:0] iq_cr_dst,
    input wire logic [1:0][1:0] iq_ser,
    input wire logic [1:0] iq_int_or_load,
    input wire logic [1:0] iq_is_sync,
    input wire logic [1:0] iq_is_tlbsync,
    input wire logic [3:0] iq_occupancy,
    // execution unit availability
    input wire logic [5:0] eu_free,
    // finish reports by completion queue index
    input wire logic [5:0] fin_valid,
    input wire logic [5:0] fin_exception,
    // speculation state
    input wire logic unresolved_pred,
    // synchronize inputs
    input wire logic store_queue_empty,
    input wire logic bcast_enable,
    input wire logic bcast_done,
    input wire logic tlb_invalidate_sync_in,
    // branch unit
    input wire logic br_valid,
    input wire logic br_to_link,
    input wire logic br_to_count,
    input wire logic br_and_link,
    input wire logic br_on_cond_bits,
    input wire logic br_updates_ctr,
    input wire logic br_taken,
    input wire logic link_avail,
    input wire logic count_avail,
    input wire logic shadow_link_avail,
    // results
    output logic [1:0] dispatch_ff,
    output logic [1:0] retire_ff,
    output logic [1:0] retire_exception_ff,
    output logic sru_busy_ff,
    output logic [2:0] cq_count_ff,
    output logic [2:0] int_free_ff,
    output logic [2:0] flt_free_ff,
    output logic br_stall_ff,
    output logic br_fold_ff,
    output logic br_fall_ff
);
    // completion queue storage, circular
    logic [5:0] cq_val_ff;
    logic [5:0] cq_fin_ff;
    logic [5:0] cq_exc_ff;
    logic [5:0] cq_spec_ff;
    logic [5:0] cq_il_ff;
    logic [5:0] cq_tlbs_ff;
    logic [5:0] cq_cr_ff;
    logic [5:0][1:0] cq_int_ff;
    logic [5:0] cq_flt_ff;
    logic [2:0] head_ff;
    logic [2:0] tail_ff;
    logic [2:0] cnt_ff;
    dcc_pkg::dcc_sru_type sru_state_ff;
    logic [3:0] sru_cnt_ff;
    logic cser_busy_ff;

    logic [1:0] disp;
    logic [1:0] ret;
    logic [1:0][1:0] need_int;
    logic [2:0] int_free;
    logic [2:0] flt_free;
    logic [2:0] int_alloc;
    logic [2:0] flt_alloc;
    logic [2:0] int_rel;
    logic [2:0] flt_rel;
    logic [2:0] h1;
    logic [2:0] t1;
    logic sru_go;
    logic sru_sync;
    logic [3:0] sru_len;
    logic br_stall;
    logic br_fold;
    logic br_fall;

    function automatic logic [2:0] wrap_inc(input logic [2:0] p, input logic [2:0] n);
        logic [3:0] s;
        s = 4'(p) + 4'(n);
        if (s >= 4'(dcc_pkg::CQ_DEPTH)) begin
            s = s - 4'(dcc_pkg::CQ_DEPTH);
        end
        return s[2:0];
    endfunction

    // rename needs per slot
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            need_int[i] = iq_load_update[i] ? 2'h2 : {1'b0, iq_int_dst[i]}; // RULE5
        end
    end

    // dispatch decision for both slots
    always_comb begin
        logic ser0;
        logic sys_blk;
        ser0 = (iq_ser[0] == 2'(dcc_pkg::DCC_SER_COMPL))
            || (iq_ser[0] == 2'(dcc_pkg::DCC_SER_REFETCH));
        sys_blk = (iq_unit[0] == dcc_pkg::EU_SRU) && sru_busy_ff;
        disp = 2'h0;
        disp[0] = iq_valid[0] && eu_free[iq_unit[0]] && !sys_blk
            && (3'(need_int[0]) <= int_free) && (3'(iq_flt_dst[0]) <= flt_free) // RULE4
            && (cnt_ff < 3'(dcc_pkg::CQ_DEPTH)) && !cser_busy_ff; // RULE1
        disp[1] = disp[0] && iq_valid[1] && !ser0 // RULE2
            && eu_free[iq_unit[1]]
            && !((iq_unit[1] == iq_unit[0]) && (iq_unit[0] != dcc_pkg::EU_INT))
            && (iq_unit[1] != dcc_pkg::EU_SRU || iq_unit[0] != dcc_pkg::EU_SRU)
            && (4'(need_int[0]) + 4'(need_int[1]) <= 4'(int_free))
            && (3'(iq_flt_dst[0]) + 3'(iq_flt_dst[1]) <= flt_free) // RULE6
            && (cnt_ff + 3'h1 < 3'(dcc_pkg::CQ_DEPTH)) // RULE3
            && (4'(cnt_ff) + iq_occupancy <= 4'(dcc_pkg::MAX_INFLIGHT)); // RULE11
    end

    // completion decision, oldest entry first
    always_comb begin
        logic ok0;
        logic ok1;
        logic [2:0] crs;
        logic [2:0] ints;
        logic [2:0] flts;
        h1 = wrap_inc(head_ff, 3'h1);
        ok0 = cq_val_ff[head_ff] && cq_fin_ff[head_ff] && !cq_spec_ff[head_ff]
            && !cq_exc_ff[head_ff] // RULE7
            && (!cq_tlbs_ff[head_ff] || tlb_invalidate_sync_in); // RULE16
        crs = 3'(cq_cr_ff[head_ff]) + 3'(cq_cr_ff[h1]);
        ints = 3'(cq_int_ff[head_ff]) + 3'(cq_int_ff[h1]);
        flts = 3'(cq_flt_ff[head_ff]) + 3'(cq_flt_ff[h1]);
        ok1 = ok0 && cq_val_ff[h1] && cq_fin_ff[h1] && !cq_spec_ff[h1]
            && !cq_exc_ff[h1] // RULE8
            && cq_il_ff[h1] && !cq_tlbs_ff[h1] // RULE9
            && crs <= 3'(dcc_pkg::MAX_UPD) && ints <= 3'(dcc_pkg::MAX_UPD)
            && flts <= 3'(dcc_pkg::MAX_UPD); // RULE10
        ret = {ok1, ok0}; // RULE20
    end

    // rename release at retirement, allocation at dispatch
    always_comb begin
        int_alloc = (disp[0] ? 3'(need_int[0]) : 3'h0) + (disp[1] ? 3'(need_int[1]) : 3'h0);
        flt_alloc = 3'(disp[0] && iq_flt_dst[0]) + 3'(disp[1] && iq_flt_dst[1]);
        int_rel = (ret[0] ? 3'(cq_int_ff[head_ff]) : 3'h0) + (ret[1] ? 3'(cq_int_ff[h1]) : 3'h0);
        flt_rel = 3'(ret[0] && cq_flt_ff[head_ff]) + 3'(ret[1] && cq_flt_ff[h1]);
        t1 = wrap_inc(tail_ff, 3'h1);
    end

    dcc_rename_pool u_int_pool (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .alloc_cnt(int_alloc),
        .release_cnt(int_rel), // RULE20
        .free_ff(int_free)
    );

    dcc_rename_pool u_flt_pool (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .alloc_cnt(flt_alloc),
        .release_cnt(flt_rel),
        .free_ff(flt_free)
    );

    // completion queue entries
    generate
        for (genvar e = 0; e < dcc_pkg::CQ_DEPTH; e++) begin : g_cq
            logic wr0;
            logic wr1;
            logic clr;
            assign wr0 = disp[0] && (tail_ff == 3'(e));
            assign wr1 = disp[1] && (t1 == 3'(e));
            assign clr = (ret[0] && head_ff == 3'(e)) || (ret[1] && h1 == 3'(e));
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    cq_val_ff[e] <= 1'b0;
                    cq_fin_ff[e] <= 1'b0;
                    cq_exc_ff[e] <= 1'b0;
                    cq_spec_ff[e] <= 1'b0;
                    cq_il_ff[e] <= 1'b0;
                    cq_tlbs_ff[e] <= 1'b0;
                    cq_cr_ff[e] <= 1'b0;
                    cq_int_ff[e] <= 2'h0;
                    cq_flt_ff[e] <= 1'b0;
                end else if (wr0 || wr1) begin
                    cq_val_ff[e] <= 1'b1;
                    cq_fin_ff[e] <= wr0 ? iq_is_tlbsync[0] : iq_is_tlbsync[1]; // RULE16
                    cq_exc_ff[e] <= 1'b0;
                    cq_spec_ff[e] <= unresolved_pred;
                    cq_il_ff[e] <= wr0 ? iq_int_or_load[0] : iq_int_or_load[1];
                    cq_tlbs_ff[e] <= wr0 ? iq_is_tlbsync[0] : iq_is_tlbsync[1];
                    cq_cr_ff[e] <= wr0 ? iq_cr_dst[0] : iq_cr_dst[1];
                    cq_int_ff[e] <= wr0 ? need_int[0] : need_int[1];
                    cq_flt_ff[e] <= wr0 ? iq_flt_dst[0] : iq_flt_dst[1];
                end else if (clr) begin
                    cq_val_ff[e] <= 1'b0;
                    cq_fin_ff[e] <= 1'b0;
                end else begin
                    if (fin_valid[e]) begin
                        cq_fin_ff[e] <= 1'b1;
                        cq_exc_ff[e] <= fin_exception[e];
                    end
                    if (!unresolved_pred) begin
                        cq_spec_ff[e] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // pointers and occupancy
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            head_ff <= 3'h0;
            tail_ff <= 3'h0;
            cnt_ff <= 3'h0;
        end else begin
            head_ff <= wrap_inc(head_ff, 3'(ret[0]) + 3'(ret[1])); // RULE20
            tail_ff <= wrap_inc(tail_ff, 3'(disp[0]) + 3'(disp[1]));
            cnt_ff <= cnt_ff + 3'(disp[0]) + 3'(disp[1]) - 3'(ret[0]) - 3'(ret[1]); // RULE3
        end
    end

    // completion serializer blocks dispatch
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cser_busy_ff <= 1'b0;
        end else if (disp[0] && iq_ser[0] == 2'(dcc_pkg::DCC_SER_COMPL)) begin
            cser_busy_ff <= 1'b1; // RULE1
        end else if (ret[0] && cnt_ff <= 3'(ret[0]) + 3'(ret[1])) begin
            cser_busy_ff <= 1'b0;
        end
    end

    // system register unit latency selection
    always_comb begin
        sru_go = disp[0] && iq_unit[0] == dcc_pkg::EU_SRU;
        sru_sync = iq_is_sync[0];
        if (iq_opcode[0] == dcc_pkg::OPC_CR_LOGIC) begin
            sru_len = dcc_pkg::SRU_CR_CYCLES; // RULE17
        end else if (iq_opcode[0] == dcc_pkg::OPC_EXT31
            && (iq_xop[0] == dcc_pkg::XOP_SEG_IND || iq_xop[0] == dcc_pkg::XOP_SEG_DIR)) begin
            sru_len = dcc_pkg::SRU_SEG_CYCLES; // RULE18
        end else if (sru_sync) begin
            sru_len = dcc_pkg::SYNC_CYCLES; // RULE15
        end else begin
            sru_len = dcc_pkg::SRU_CR_CYCLES;
        end
    end

    // system unit busy for its latency
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sru_state_ff <= dcc_pkg::DCC_SRU_IDLE;
            sru_cnt_ff <= 4'h0;
            sru_busy_ff <= 1'b0;
        end else begin
            case (sru_state_ff)
                dcc_pkg::DCC_SRU_IDLE: begin
                    if (sru_go) begin
                        sru_state_ff <= (sru_sync && !store_queue_empty) ?
                            dcc_pkg::DCC_SRU_SYNC_DRAIN : dcc_pkg::DCC_SRU_BUSY; // RULE15
                        sru_cnt_ff <= sru_len - 4'h1;
                        sru_busy_ff <= 1'b1; // RULE17
                    end
                end
                dcc_pkg::DCC_SRU_BUSY: begin
                    if (sru_cnt_ff == 4'h0) begin
                        sru_state_ff <= dcc_pkg::DCC_SRU_IDLE;
                        sru_busy_ff <= 1'b0;
                    end else begin
                        sru_cnt_ff <= sru_cnt_ff - 4'h1;
                    end
                end
                dcc_pkg::DCC_SRU_SYNC_DRAIN: begin
                    if (store_queue_empty) begin
                        sru_state_ff <= bcast_enable ? dcc_pkg::DCC_SRU_SYNC_BCAST
                            : dcc_pkg::DCC_SRU_IDLE;
                        sru_busy_ff <= bcast_enable;
                    end
                end
                dcc_pkg::DCC_SRU_SYNC_BCAST: begin
                    if (bcast_done) begin
                        sru_state_ff <= dcc_pkg::DCC_SRU_IDLE; // RULE15
                        sru_busy_ff <= 1'b0;
                    end
                end
                default: begin
                    sru_state_ff <= dcc_pkg::DCC_SRU_IDLE;
                    sru_busy_ff <= 1'b0;
                end
            endcase
        end
    end

    dcc_branch_res u_branch (
        .br_valid(br_valid),
        .br_to_link(br_to_link),
        .br_to_count(br_to_count),
        .br_and_link(br_and_link),
        .br_on_cond_bits(br_on_cond_bits),
        .br_updates_ctr(br_updates_ctr),
        .br_taken(br_taken),
        .link_avail(link_avail),
        .count_avail(count_avail),
        .shadow_link_avail(shadow_link_avail),
        .unresolved_pred(unresolved_pred),
        .br_stall(br_stall),
        .br_fold(br_fold),
        .br_fall(br_fall)
    );

    // registered outputs
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            dispatch_ff <= 2'h0;
            retire_ff <= 2'h0;
            retire_exception_ff <= 2'h0;
            cq_count_ff <= 3'h0;
            int_free_ff <= 3'h6;
            flt_free_ff <= 3'h6;
            br_stall_ff <= 1'b0;
            br_fold_ff <= 1'b0;
            br_fall_ff <= 1'b0;
        end else begin
            dispatch_ff <= disp;
            retire_ff <= ret;
            retire_exception_ff <= {1'b0, cq_val_ff[head_ff] && cq_fin_ff[head_ff]
                && cq_exc_ff[head_ff]};
            cq_count_ff <= cnt_ff;
            int_free_ff <= int_free;
            flt_free_ff <= flt_free;
            br_stall_ff <= br_stall;
            br_fold_ff <= br_fold;
            br_fall_ff <= br_fall;
        end
    end

    a_cq_limit: assert property (@(posedge clk_sys) disable iff (!resetn)
        cnt_ff <= 3'h6) else $error("completion queue over six"); // RULE3
    a_second_disp: assert property (@(posedge clk_sys) disable iff (!resetn)
        disp[1] |-> disp[0]) else $error("second slot without first"); // RULE2
    a_second_ret: assert property (@(posedge clk_sys) disable iff (!resetn)
        ret[1] |-> ret[0] && cq_il_ff[h1]) else $error("bad second retire"); // RULE9
    a_retire_done: assert property (@(posedge clk_sys) disable iff (!resetn)
        ret[0] |-> cq_fin_ff[head_ff] && !cq_exc_ff[head_ff]) else $error("retire unfinished"); // RULE7
    a_int_pool: assert property (@(posedge clk_sys) disable iff (!resetn)
        disp[0] |-> 3'(need_int[0]) <= int_free) else $error("integer rename overrun"); // RULE4
    a_flt_pool: assert property (@(posedge clk_sys) disable iff (!resetn)
        flt_free <= 3'h6) else $error("float pool corrupt"); // RULE6
    a_upd_limit: assert property (@(posedge clk_sys) disable iff (!resetn)
        ret[1] |-> 3'(cq_int_ff[head_ff]) + 3'(cq_int_ff[h1]) <= 3'h2)
        else $error("too many integer updates"); // RULE10
    a_ret_reg: assert property (@(posedge clk_sys) disable iff (!resetn)
        ret[0] |=> retire_ff[0]) else $error("retire output lost"); // RULE20
    a_seg_two: assert property (@(posedge clk_sys) disable iff (!resetn)
        sru_go && sru_len == 4'h2 && !sru_sync |=> sru_busy_ff[*2] ##1 !sru_busy_ff)
        else $error("segment move not two cycles"); // RULE18
    a_tlbs_wait: assert property (@(posedge clk_sys) disable iff (!resetn)
        ret[0] && cq_tlbs_ff[head_ff] |-> tlb_invalidate_sync_in)
        else $error("tlb sync retired early"); // RULE16
    c_dual_disp: cover property (@(posedge clk_sys) disable iff (!resetn) disp == 2'h3);
    c_dual_ret: cover property (@(posedge clk_sys) disable iff (!resetn) ret == 2'h3);
    c_cq_full: cover property (@(posedge clk_sys) disable iff (!resetn) cnt_ff == 3'h6);
    c_sync_drain: cover property (@(posedge clk_sys) disable iff (!resetn)
        sru_state_ff == dcc_pkg::DCC_SRU_SYNC_DRAIN);
endmodule

// >>> bench/dcc_exec_model.sv
// model of the execution units beyond the block
`timescale 1ns/100ps
module dcc_exec_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // bench controls
    input wire logic run,
    input wire logic [1:0] gap,
    input wire logic tlb_allow,
    // to the block
    output logic [5:0] fin_valid,
    output logic [5:0] fin_exception,
    output logic tlb_invalidate_sync_in
);
    logic [1:0] wait_ff;
    // finish reports after a random gap
    always_ff @(posedge clk_sys) begin
        if (!resetn || !run || wait_ff != 2'h0) begin
            fin_valid <= 6'h00;
        end else begin
            fin_valid <= 6'h3f;
        end
        wait_ff <= (!resetn || wait_ff == 2'h0) ? gap : wait_ff - 2'h1;
    end
    // no unit here raises exceptions
    assign fin_exception = 6'h00;
    // sync input follows the bench
    assign tlb_invalidate_sync_in = tlb_allow;
endmodule

// >>> bench/test_dispatch_completion_control.sv
// self-checking bench for the dispatch and completion control
`timescale 1ns/100ps
module test_dispatch_completion_control;
    logic clk_sys, resetn, unresolved_pred, store_queue_empty, run, tlb_allow;
    logic [1:0] iq_valid, iq_int_dst, iq_load_update, iq_flt_dst, iq_cr_dst, iq_int_or_load;
    logic [1:0] iq_is_sync, iq_is_tlbsync, gap, dispatch_ff, retire_ff;
    logic [1:0][2:0] iq_unit;
    logic [1:0][5:0] iq_opcode;
    logic [1:0][9:0] iq_xop;
    logic [1:0][1:0] iq_ser;
    logic [5:0] eu_free, fin_valid, fin_exception;
    logic [9:0] brv;
    logic [2:0] cq_count_ff, int_free_ff, flt_free_ff;
    logic sru_busy_ff, br_stall_ff, br_fold_ff, br_fall_ff, tlb_invalidate_sync_in;
    logic [31:0] seed = 32'h48a9;
    logic [3:0] busy_n = 4'h0;
    logic [3:0] dq[$], bq[$], sq[$];
    logic [15:0] ops[4] = '{16'h4d01, 16'h7cf2, 16'h7cd2, 16'h7e56};
    logic [3:0] lens[4] = '{4'h1, 4'h2, 4'h2, 4'h3};
    int miscompares, compares, cycles, retired;

    dcc_core_ctrl dcc_core_ctrl_inst (.clk_sys, .resetn, .iq_valid, .iq_unit, .iq_opcode,
        .iq_xop, .iq_int_dst, .iq_load_update, .iq_flt_dst, .iq_cr_dst, .iq_ser,
        .iq_int_or_load, .iq_is_sync, .iq_is_tlbsync, .iq_occupancy(4'h2), .eu_free,
        .fin_valid, .fin_exception, .unresolved_pred, .store_queue_empty,
        .bcast_enable(1'b0), .bcast_done(1'b0), .tlb_invalidate_sync_in,
        .br_valid(brv[0]), .br_to_link(brv[1]), .br_to_count(brv[2]), .br_and_link(brv[3]),
        .br_on_cond_bits(brv[4]), .br_updates_ctr(brv[5]), .br_taken(brv[6]),
        .link_avail(brv[7]), .count_avail(brv[8]), .shadow_link_avail(brv[9]),
        .dispatch_ff, .retire_ff, .retire_exception_ff(), .sru_busy_ff, .cq_count_ff,
        .int_free_ff, .flt_free_ff, .br_stall_ff, .br_fold_ff, .br_fall_ff);
    dcc_exec_model dcc_exec_model_inst (.clk_sys, .resetn, .run, .gap, .tlb_allow,
        .fin_valid, .fin_exception, .tlb_invalidate_sync_in);

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected {stall, fold, fall}
    function automatic logic [2:0] br_exp(input logic [9:0] b, input logic u);
        logic s;
        s = b[0] & ((b[1] & !b[7]) | (b[2] & !b[8]) | (b[3] & !b[9]) | (b[4] & u));
        return {s, b[0] & !s & !b[5] & !b[3] & b[6], b[0] & !s & !b[5] & !b[3] & !b[6]};
    endfunction
    task automatic cmp(input string n, input logic [3:0] e, input logic [3:0] s);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // load one slot; f = {tlbsync, sync, cr, float, load update, int}
    task automatic slot(input int s, input logic [2:0] u, input logic [15:0] op,
                        input logic [1:0] ser, input logic [5:0] f);
        iq_unit[s] = u;
        {iq_opcode[s], iq_xop[s]} = op;
        iq_ser[s] = ser;
        {iq_is_tlbsync[s], iq_is_sync[s], iq_cr_dst[s]} = f[5:3];
        {iq_flt_dst[s], iq_load_update[s], iq_int_dst[s]} = f[2:0];
        iq_int_or_load[s] = (u == dcc_pkg::EU_INT) || (u == dcc_pkg::EU_LSU);
    endtask
    // present slots one cycle, note expected dispatch
    task automatic go(input logic [1:0] v, input logic [1:0] e);
        gap = 2'(xs());
        iq_valid = v;
        if (e != 2'h0) dq.push_back({2'h0, e});
        @(negedge clk_sys);
        iq_valid = 2'h0;
        @(negedge clk_sys);
    endtask
    // finish all, check resources returned
    task automatic drain();
        run = 1'b1;
        for (int i = 0; i < 200 && cq_count_ff !== 3'h0; i++) @(negedge clk_sys);
        repeat (2) @(negedge clk_sys);
        cmp("cq_count", 4'h0, cq_count_ff);
        cmp("int_free", 4'h6, int_free_ff);
        cmp("flt_free", 4'h6, flt_free_ff);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // watch outputs after each rising edge
    always @(posedge clk_sys) begin
        #1;
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
        if (dispatch_ff != 2'h0) cmp("dispatch", dq.size() ? dq.pop_front() : 4'hf, dispatch_ff);
        if (bq.size() != 0) cmp("branch", bq.pop_front(), {br_stall_ff, br_fold_ff, br_fall_ff});
        if (retire_ff == 2'h2) cmp("retire", 4'h1, retire_ff);
        retired += retire_ff[0] + retire_ff[1];
        if (sru_busy_ff === 1'b1) busy_n++;
        else if (busy_n != 4'h0) begin
            cmp("busy", sq.size() ? sq.pop_front() : 4'hf, busy_n);
            busy_n = 4'h0;
        end
    end
    // main sequence
    initial begin
        {resetn, unresolved_pred, run, iq_valid, gap, brv} = '0;
        {iq_unit, iq_opcode, iq_xop, iq_ser, iq_int_dst, iq_load_update} = '0;
        {iq_flt_dst, iq_cr_dst, iq_int_or_load, iq_is_sync, iq_is_tlbsync} = '0;
        {store_queue_empty, tlb_allow, eu_free} = {2'h3, 6'h3f};
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        drain();
        run = 1'b0;
        slot(1, dcc_pkg::EU_INT, 16'h7d0a, 2'h0, 6'h01);
        go(2'h2, 2'h0);
        slot(0, dcc_pkg::EU_LSU, 16'h8c00, 2'h0, 6'h03);
        go(2'h3, 2'h3);
        slot(0, dcc_pkg::EU_FLT, 16'hfc2a, 2'h0, 6'h04);
        slot(1, dcc_pkg::EU_FLT, 16'hfc2a, 2'h0, 6'h04);
        go(2'h3, 2'h1);
        cmp("int_free", 4'h3, int_free_ff);
        eu_free = 6'h3b;
        go(2'h1, 2'h0);
        eu_free = 6'h3f;
        for (int i = 0; i < 3; i++) go(2'h1, 2'h1);
        slot(0, dcc_pkg::EU_INT, 16'h7d0a, 2'h0, 6'h01);
        go(2'h1, 2'h0);
        cmp("cq_count", 4'h6, cq_count_ff);
        cmp("flt_free", 4'h2, flt_free_ff);
        drain();
        cmp("retired", 4'h6, 4'(retired));
        run = 1'b0;
        slot(0, dcc_pkg::EU_LSU, 16'h8c00, 2'h0, 6'h03);
        for (int i = 0; i < 3; i++) go(2'h1, 2'h1);
        slot(0, dcc_pkg::EU_FLT, 16'hfc2a, 2'h0, 6'h04);
        go(2'h1, 2'h1);
        slot(0, dcc_pkg::EU_INT, 16'h7d0a, 2'h0, 6'h01);
        go(2'h1, 2'h0);
        cmp("int_free", 4'h0, int_free_ff);
        drain();
        // completion- or refetch-serialized first slot keeps second back
        for (int k = 2; k < 4; k++) begin
            slot(0, dcc_pkg::EU_INT, 16'h7d0a, 2'(k), 6'h01);
            slot(1, dcc_pkg::EU_INT, 16'h7d0a, 2'h0, 6'h01);
            go(2'h3, 2'h1);
            drain();
        end
        // retire held by speculation, then sync input
        for (int k = 0; k < 2; k++) begin
            {unresolved_pred, tlb_allow} = (k == 0) ? 2'h3 : 2'h0;
            slot(0, k ? dcc_pkg::EU_NONE : dcc_pkg::EU_INT, k ? 16'h7e36 : 16'h7d0a, 2'h0,
                 k ? 6'h20 : 6'h01);
            go(2'h1, 2'h1);
            repeat (20) @(negedge clk_sys);
            cmp("held", 4'h1, cq_count_ff);
            {unresolved_pred, tlb_allow} = 2'h1;
            drain();
        end
        // system unit busy time
        for (int k = 0; k < 4; k++) begin
            slot(0, dcc_pkg::EU_SRU, ops[k], 2'h1, k == 0 ? 6'h08 : (k == 3 ? 6'h10 : 6'h00));
            sq.push_back(lens[k]);
            go(2'h1, 2'h1);
            repeat (8) @(negedge clk_sys);
        end
        // random branches
        for (int i = 0; i < 300; i++) begin
            {unresolved_pred, brv} = 11'(xs());
            bq.push_back({1'b0, br_exp(brv, unresolved_pred)});
            @(negedge clk_sys);
        end
        {unresolved_pred, brv} = '0;
        drain();
        cmp("leftover", 4'h0, 4'(dq.size() + sq.size()));
        conclude();
    end
endmodule
